// >>> disk_address_pkg.sv
// Operation
// - on positioned-ready rise copy target cylinder into present cylinder
// - every change of target cylinder issues a fresh seek to the drive
// - auto advance past highest cylinder sets address overflow error
// - software write above highest cylinder sets invalid address error
// - header word one cylinder equal to target raises cylinder match
// - target track drives five head-select lines, no positioner motion
// - sector/track register loads on select and write strobe together
// - with go set, track advances after last sector of each track
// - track runs 0 to 18, flag at 18, then wraps to 0
// - header word two track and sector against target and counter
// - target sector equal to rotational counter raises sector match
// - during transfer sector field increments at each end of block
// - last-sector signal clears sector field of target register
// - target cylinder write accepted only while go flag is clear
// - magnitude of target minus present on nine lines, borrow means reverse
// - cylinder increments after last track of cylinder, causing seek
package disk_address_pkg;
    localparam int CYL_W = 9;
    localparam int TRK_W = 5;
    localparam int SEC_W = 5;
    localparam logic [CYL_W-1:0] MAX_CYLINDER = 9'h19a;
    localparam logic [TRK_W-1:0] FINAL_TRACK  = 5'h12;
    localparam logic [3:0] ADDR_TARGET_CYL = 4'h0;
    localparam logic [3:0] ADDR_SECT_TRK   = 4'h1;
    localparam logic [3:0] ADDR_STATUS     = 4'h2;
    localparam logic [3:0] ADDR_CONTROL    = 4'h3;
    localparam logic [3:0] ADDR_HEADER     = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLEAR  = 4'h7;
    localparam int SECT_LSB = 0;
    localparam int TRK_LSB  = 8;
    localparam int CTRL_GO  = 0;
    localparam int CTRL_CLR = 1;
    localparam int IRQ_AOE  = 0;
    localparam int IRQ_IAE  = 1;
    localparam int IRQ_SEEK = 2;
    localparam int IRQ_W    = 3;
endpackage

// >>> cylinder_seek.sv
`timescale 1ns/100ps
module cylinder_seek (
    input  wire logic                               sys_clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               ce_i,
    input  wire logic [disk_address_pkg::CYL_W-1:0] target_cylinder_i,
    input  wire logic                               ready_sync_i,
    output logic      [disk_address_pkg::CYL_W-1:0] present_cylinder_o,
    output logic      [disk_address_pkg::CYL_W-1:0] cylinder_difference_o,
    output logic                                    seek_direction_reverse_o,
    output logic                                    seek_go_o,
    output logic                                    seek_done_o
);
    logic [disk_address_pkg::CYL_W-1:0] present_ff;
    logic [disk_address_pkg::CYL_W-1:0] last_target_ff;
    logic                               ready_d_ff;
    wire  [disk_address_pkg::CYL_W:0]   diff_full;
    wire  [disk_address_pkg::CYL_W-1:0] diff_mag;
    wire                                ready_rise;
    wire                                target_changed;

    assign diff_full      = {1'b0, target_cylinder_i} - {1'b0, present_ff};
    assign diff_mag       = diff_full[disk_address_pkg::CYL_W] ? (present_ff - target_cylinder_i)
                                                               : diff_full[disk_address_pkg::CYL_W-1:0];
    assign ready_rise     = ready_sync_i & ~ready_d_ff;
    assign target_changed = target_cylinder_i != last_target_ff;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            present_ff               <= 9'h000;
            last_target_ff           <= 9'h000;
            ready_d_ff               <= 1'b1;
            cylinder_difference_o    <= 9'h000;
            seek_direction_reverse_o <= 1'b0;
            seek_go_o                <= 1'b0;
            seek_done_o              <= 1'b0;
        end else if (ce_i) begin
            ready_d_ff     <= ready_sync_i;
            last_target_ff <= target_cylinder_i;
            seek_go_o      <= target_changed;
            seek_done_o    <= ready_rise;
            if (ready_rise) begin
                present_ff <= target_cylinder_i;
            end
            cylinder_difference_o    <= diff_mag;
            seek_direction_reverse_o <= diff_full[disk_address_pkg::CYL_W];
        end
    end
    assign present_cylinder_o = present_ff;
endmodule

// >>> disk_address_compare.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
module disk_address_compare (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        drive_positioned_ready_i,
    input  wire logic [4:0]  sector_count_i,
    input  wire logic        end_of_block_pulse_i,
    input  wire logic        last_sector_flag_i,
    input  wire logic        header_word1_valid_i,
    input  wire logic        header_word2_valid_i,
    input  wire logic [15:0] header_word_i,
    output logic      [4:0]  head_select_bits_o,
    output logic      [8:0]  cylinder_difference_o,
    output logic             seek_direction_reverse_o,
    output logic             seek_go_o,
    output logic             cylinder_match_o,
    output logic             sector_track_match_o,
    output logic             sector_match_o,
    output logic             final_track_flag_o,
    output logic             irq_o
);
    logic [8:0]  target_cylinder_ff;
    logic [4:0]  track_ff;
    logic [4:0]  sector_ff;
    logic        go_flag_ff;
    logic        address_overflow_error_ff;
    logic        invalid_address_error_ff;
    logic [2:0]  irq_status_ff;
    logic [2:0]  irq_enable_ff;
    logic        ready_meta_ff;
    logic        ready_sync_ff;
    logic        eob_meta_ff;
    logic        eob_sync_ff;
    logic        eob_d_ff;
    logic        last_meta_ff;
    logic        last_sync_ff;
    logic [4:0]  sect_cnt_meta_ff;
    logic [4:0]  sect_cnt_sync_ff;
    logic [4:0]  sect_cnt_prev_ff;
    logic [4:0]  sect_cnt_stable_ff;
    logic [8:0]  present_cylinder;
    logic [8:0]  diff_w;
    logic        dir_w;
    logic        go_w;
    logic        seek_done;

    function automatic logic reg_hit(input logic [11:0] a, input logic [3:0] idx);
        reg_hit = a[11:2] == {6'h00, idx};
    endfunction

    // a write lands only at the edge that completes the transfer
    wire         access       = psel & penable & pready;
    wire         wr           = access & pwrite;
    wire         wr_cyl       = wr & reg_hit(paddr, disk_address_pkg::ADDR_TARGET_CYL);
    wire         wr_st        = wr & reg_hit(paddr, disk_address_pkg::ADDR_SECT_TRK);
    wire         wr_ctrl      = wr & reg_hit(paddr, disk_address_pkg::ADDR_CONTROL);
    wire         wr_ien       = wr & reg_hit(paddr, disk_address_pkg::ADDR_IRQ_ENABLE);
    wire         wr_iclr      = wr & reg_hit(paddr, disk_address_pkg::ADDR_IRQ_CLEAR);
    wire         ctrl_clear   = wr_ctrl & pwdata[disk_address_pkg::CTRL_CLR];
    wire         cyl_accept   = wr_cyl & ~go_flag_ff;
    wire         bad_cyl      = pwdata[8:0] > disk_address_pkg::MAX_CYLINDER | (|pwdata[15:9]);
    wire         eob          = eob_sync_ff & ~eob_d_ff;
    wire         sect_advance = go_flag_ff & eob;
    wire         track_end    = sect_advance & last_sync_ff;
    wire         at_final     = track_ff == disk_address_pkg::FINAL_TRACK;
    wire         cyl_advance  = track_end & at_final;
    wire         cyl_over     = cyl_advance & (target_cylinder_ff >= disk_address_pkg::MAX_CYLINDER);
    wire         mapped       = paddr[11:5] == 7'h00;
    // the counter word is taken only after two equal samples, so no torn value is compared
    wire         sect_settled = sect_cnt_sync_ff == sect_cnt_prev_ff;
    wire  [2:0]  irq_events   = {seek_done, cyl_accept & bad_cyl, cyl_over};
    wire  [31:0] rd_mux       =
        reg_hit(paddr, disk_address_pkg::ADDR_TARGET_CYL) ? {23'h000000, target_cylinder_ff} :
        reg_hit(paddr, disk_address_pkg::ADDR_SECT_TRK)   ? {19'h00000, track_ff, 3'h0, sector_ff} :
        reg_hit(paddr, disk_address_pkg::ADDR_STATUS)     ? {10'h000, present_cylinder, dir_w, diff_w,
                                                             go_w, invalid_address_error_ff,
                                                             address_overflow_error_ff} :
        reg_hit(paddr, disk_address_pkg::ADDR_CONTROL)    ? {31'h00000000, go_flag_ff} :
        reg_hit(paddr, disk_address_pkg::ADDR_IRQ_STATUS) ? {29'h00000000, irq_status_ff} :
        reg_hit(paddr, disk_address_pkg::ADDR_IRQ_ENABLE) ? {29'h00000000, irq_enable_ff} :
                                                            32'h00000000;

    cylinder_seek u_seek (
        .sys_clk_i                (sys_clk_i),
        .rst_i                    (rst_i),
        .ce_i                     (ce_i),
        .target_cylinder_i        (target_cylinder_ff),
        .ready_sync_i             (ready_sync_ff),
        .present_cylinder_o       (present_cylinder),
        .cylinder_difference_o    (diff_w),
        .seek_direction_reverse_o (dir_w),
        .seek_go_o                (go_w),
        .seek_done_o              (seek_done)
    );

    // two-stage synchronisers for drive-side inputs
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // the drive idles ready, so no false rise follows reset
            ready_meta_ff    <= 1'b1;
            ready_sync_ff    <= 1'b1;
            eob_meta_ff      <= 1'b0;
            eob_sync_ff      <= 1'b0;
            eob_d_ff         <= 1'b0;
            last_meta_ff     <= 1'b0;
            last_sync_ff     <= 1'b0;
            sect_cnt_meta_ff <= 5'h00;
            sect_cnt_sync_ff <= 5'h00;
            sect_cnt_prev_ff   <= 5'h00;
            sect_cnt_stable_ff <= 5'h00;
        end else if (ce_i) begin
            ready_meta_ff    <= drive_positioned_ready_i;
            ready_sync_ff    <= ready_meta_ff;
            eob_meta_ff      <= end_of_block_pulse_i;
            eob_sync_ff      <= eob_meta_ff;
            eob_d_ff         <= eob_sync_ff;
            last_meta_ff     <= last_sector_flag_i;
            last_sync_ff     <= last_meta_ff;
            sect_cnt_meta_ff <= sector_count_i;
            sect_cnt_sync_ff <= sect_cnt_meta_ff;
            sect_cnt_prev_ff <= sect_cnt_sync_ff;
            if (sect_settled) begin
                sect_cnt_stable_ff <= sect_cnt_sync_ff;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_cylinder_ff <= 9'h000;
        end else if (ce_i) begin
            if (cyl_accept) begin
                target_cylinder_ff <= pwdata[8:0];
            end else if (cyl_advance) begin
                target_cylinder_ff <= target_cylinder_ff + 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            track_ff  <= 5'h00;
            sector_ff <= 5'h00;
        end else if (ce_i) begin
            if (wr_st) begin
                sector_ff <= pwdata[disk_address_pkg::SECT_LSB +: disk_address_pkg::SEC_W];
                track_ff  <= pwdata[disk_address_pkg::TRK_LSB +: disk_address_pkg::TRK_W];
            end else if (sect_advance) begin
                sector_ff <= last_sync_ff ? 5'h00 : sector_ff + 5'h01;
                if (track_end) begin
                    track_ff <= at_final ? 5'h00 : track_ff + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            go_flag_ff                <= 1'b0;
            address_overflow_error_ff <= 1'b0;
            invalid_address_error_ff  <= 1'b0;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                go_flag_ff <= pwdata[disk_address_pkg::CTRL_GO];
            end
            // sets win over the controller clear
            address_overflow_error_ff <= cyl_over | (address_overflow_error_ff & ~ctrl_clear);
            invalid_address_error_ff  <= (cyl_accept & bad_cyl) |
                                         (invalid_address_error_ff & ~ctrl_clear);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status_ff <= 3'h0;
            irq_enable_ff <= 3'h0;
            irq_o         <= 1'b0;
        end else if (ce_i) begin
            irq_status_ff <= irq_events | (irq_status_ff & ~(wr_iclr ? pwdata[2:0] : 3'h0));
            if (wr_ien) begin
                irq_enable_ff <= pwdata[2:0];
            end
            irq_o <= |(irq_status_ff & irq_enable_ff);
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            head_select_bits_o       <= 5'h00;
            cylinder_difference_o    <= 9'h000;
            seek_direction_reverse_o <= 1'b0;
            seek_go_o                <= 1'b0;
            cylinder_match_o         <= 1'b0;
            sector_track_match_o     <= 1'b0;
            sector_match_o           <= 1'b0;
            final_track_flag_o       <= 1'b0;
        end else if (ce_i) begin
            head_select_bits_o       <= track_ff;
            cylinder_difference_o    <= diff_w;
            seek_direction_reverse_o <= dir_w;
            seek_go_o                <= go_w;
            cylinder_match_o         <= header_word1_valid_i &
                                        (header_word_i[8:0] == target_cylinder_ff);
            sector_track_match_o     <= header_word2_valid_i &
                                        (header_word_i[12:8] == track_ff) &
                                        (header_word_i[4:0] == sect_cnt_stable_ff);
            sector_match_o           <= sector_ff == sect_cnt_stable_ff;
            final_track_flag_o       <= at_final;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce_i) begin
            pready  <= psel & ~pready & ~penable | (psel & penable & ~pready);
            pslverr <= psel & ~mapped;
            prdata  <= rd_mux;
        end
    end
endmodule

// >>> disk_address_compare_sva.sv
`timescale 1ns/100ps
module disk_address_compare_sva (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  head_select_bits_o,
    input wire logic [8:0]  cylinder_difference_o,
    input wire logic        seek_direction_reverse_o,
    input wire logic        seek_go_o,
    input wire logic        final_track_flag_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire unmapped = paddr >= 12'h020;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    sequence s_track_steady;
        $stable(head_select_bits_o) ##1 $stable(head_select_bits_o);
    endsequence
    a_one_wait: assert property (s_setup |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (s_done |=> !pready)
        else $error("pready held");
    a_seek_pulse: assert property (seek_go_o |=> !seek_go_o)
        else $error("seek_go held");
    a_dir_zero: assert property (cylinder_difference_o == 9'h000 |-> !seek_direction_reverse_o)
        else $error("reverse with zero difference");
    a_final_track: assert property (s_track_steady |-> final_track_flag_o == (head_select_bits_o == 5'h12))
        else $error("final track flag wrong");
    a_bad_addr: assert property ((s_done and unmapped) |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_good_addr: assert property ((s_done and !unmapped) |-> !pslverr)
        else $error("mapped access refused");
    a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !seek_go_o && !pready && cylinder_difference_o == 9'h000)
        else $error("outputs active after reset");
endmodule

// >>> drive_model.sv
`timescale 1ns/100ps
module drive_model #(parameter int SETTLE = 12) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic seek_go_i,
    output logic      drive_positioned_ready_o
);
    int cnt_ff;
    // only a seek moves the heads; head select changes leave ready high
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 0;
            drive_positioned_ready_o <= 1'b1;
        end else if (seek_go_i) begin
            cnt_ff <= SETTLE;
            drive_positioned_ready_o <= 1'b0;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
            drive_positioned_ready_o <= (cnt_ff == 1);
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/100ps
module tb;
    logic        sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err, eob, last_sec, hv1, hv2;
    logic        ready, seek_go, rev, cyl_m, st_m, sec_m, fin, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] hword;
    logic [8:0]  diff;
    logic [4:0]  sec_cnt, hsel;
    int          fail_count, n_tests;
    disk_address_compare i_dut (.sys_clk_i, .rst_i, .ce_i(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .drive_positioned_ready_i(ready), .sector_count_i(sec_cnt),
        .end_of_block_pulse_i(eob), .last_sector_flag_i(last_sec), .header_word1_valid_i(hv1),
        .header_word2_valid_i(hv2), .header_word_i(hword), .head_select_bits_o(hsel),
        .cylinder_difference_o(diff), .seek_direction_reverse_o(rev), .seek_go_o(seek_go),
        .cylinder_match_o(cyl_m), .sector_track_match_o(st_m), .sector_match_o(sec_m),
        .final_track_flag_o(fin), .irq_o(irq));
    drive_model i_drive (.sys_clk_i, .rst_i, .seek_go_i(seek_go), .drive_positioned_ready_o(ready));
    task automatic end_sim;
        $display("counts: %0d mismatches in %0d checks", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic bound(input int i, input int lim);
        if (i >= lim) begin
            fail_count++;
            end_sim();
        end
    endtask
    function automatic logic [11:0] ba(input logic [3:0] ix);
        return {6'h00, ix, 2'b00};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        clk(1);
        penable <= 1'b1;
        i = 0;
        do begin
            clk(1);
            i++;
        end while (pready !== 1'b1 && i < 20);
        bound(i, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        clk(1);
    endtask
    task automatic s_seek(input logic [8:0] cyl, input logic [8:0] from);
        int i;
        apb(1'b1, ba(disk_address_pkg::ADDR_TARGET_CYL), 32'(cyl));
        for (i = 0; seek_go !== 1'b1 && i < 50; i++) clk(1);
        bound(i, 50);
        clk(1);
        chk("difference", 32'((cyl > from) ? cyl - from : from - cyl), 32'(diff));
        chk("reverse", 32'(cyl < from), 32'(rev));
        for (i = 0; !(ready === 1'b1 && diff === 9'h000) && i < 200; i++) clk(1);
        bound(i, 200);
        apb(1'b0, ba(disk_address_pkg::ADDR_STATUS), 32'h0);
        chk("present cylinder", 32'(cyl), 32'(rd[21:13]));
    endtask
    task automatic s_error;
        apb(1'b1, ba(disk_address_pkg::ADDR_IRQ_ENABLE), 32'h2);
        s_seek(9'h19a, 9'h002);
        chk("status", 32'h0, 32'(rd[1:0]));
        s_seek(9'h19b, 9'h19a);
        chk("invalid flag", 32'h1, 32'(rd[1]));
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, ba(disk_address_pkg::ADDR_CONTROL), 32'h2);
        apb(1'b0, ba(disk_address_pkg::ADDR_STATUS), 32'h0);
        chk("cleared flag", 32'h0, 32'(rd[1]));
        apb(1'b1, ba(disk_address_pkg::ADDR_IRQ_CLEAR), 32'h2);
        clk(1);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        s_seek(9'h19a, 9'h19b);
    endtask
    task automatic eob_pulse(input logic last, input logic [31:0] exp);
        last_sec <= last;
        eob <= 1'b1;
        clk(4);
        eob <= 1'b0;
        clk(6);
        last_sec <= 1'b0;
        apb(1'b0, ba(disk_address_pkg::ADDR_SECT_TRK), 32'h0);
        chk("sector track", exp, rd & 32'h1f1f);
    endtask
    task automatic s_transfer;
        apb(1'b1, ba(disk_address_pkg::ADDR_SECT_TRK), 32'h1103);
        apb(1'b1, ba(disk_address_pkg::ADDR_CONTROL), 32'h1);
        apb(1'b1, ba(disk_address_pkg::ADDR_TARGET_CYL), 32'h7);
        apb(1'b0, ba(disk_address_pkg::ADDR_TARGET_CYL), 32'h0);
        chk("locked cylinder", 32'h19a, rd);
        sec_cnt <= 5'h03;
        hword <= 16'h019a;
        hv1 <= 1'b1;
        clk(6);
        chk("sector match", 32'h1, 32'(sec_m));
        chk("head select", 32'h11, 32'(hsel));
        chk("cylinder match", 32'h1, 32'(cyl_m));
        hword <= 16'h0199;
        clk(4);
        chk("cylinder mismatch", 32'h0, 32'(cyl_m));
        hv1 <= 1'b0;
        hword <= 16'h1103;
        hv2 <= 1'b1;
        clk(4);
        chk("sector track match", 32'h1, 32'(st_m));
        sec_cnt <= 5'h04;
        clk(6);
        chk("sector track mismatch", 32'h0, 32'(st_m));
        chk("sector mismatch", 32'h0, 32'(sec_m));
        hv2 <= 1'b0;
        eob_pulse(1'b0, 32'h1104);
        eob_pulse(1'b1, 32'h1200);
        chk("final track", 32'h1, 32'(fin));
        eob_pulse(1'b1, 32'h0000);
        apb(1'b0, ba(disk_address_pkg::ADDR_STATUS), 32'h0);
        chk("overflow flag", 32'h1, 32'(rd[0]));
        apb(1'b0, ba(disk_address_pkg::ADDR_TARGET_CYL), 32'h0);
        chk("next cylinder", 32'h19b, rd);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rst_i, psel, penable, pwrite, eob, last_sec, hv1, hv2} = 8'h80;
        paddr = 12'h000;
        pwdata = 32'h0;
        hword = 16'h0000;
        sec_cnt = 5'h00;
        fail_count = 0;
        n_tests = 0;
        clk(10);
        rst_i <= 1'b0;
        clk(1);
        s_seek(9'h005, 9'h000);
        s_seek(9'h002, 9'h005);
        s_error();
        s_transfer();
        end_sim();
    end
endmodule
bind disk_address_compare disk_address_compare_sva i_sva (.sys_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .head_select_bits_o, .cylinder_difference_o, .seek_direction_reverse_o,
    .seek_go_o, .final_track_flag_o, .irq_o);
